// ===== src/uvlo_pkg.sv
// Package with timing constants and rule summary for the undervoltage lockout sequencer
// Summary of operation
// - Both supply sides are protected against undervoltage, but only the low side raises the fault output.
// - The fault output stays asserted for as long as the low-side undervoltage state lasts.
// - Each comparator result must stay low for the filter time of 10 us before it counts as a trip.
// - Gates keep following their control inputs while the filter time is still running.
// - While a supply is tripped, the switches it feeds stay off and only the low side raises the fault.
// - A low-side trip turns off all three low-side switches whatever their inputs say.
// - The fault pulse lasts at least a minimum width and is stretched while the low supply stays low.
// - After low-side recovery each low-side phase turns on again only on a fresh rising input edge.
// - A high-side trip turns off only that phase's high-side switch and raises no fault.
// - After high-side recovery that phase turns on again only on a fresh rising input edge.
package uvlo_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned UV_FILTER_NS   = 10_000;
  // Filter is a nominal figure; round down so a dip of 10 us trips
  localparam int unsigned UV_FILTER_CYC  = (UV_FILTER_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned FAULT_MIN_CYC  = 1000;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned PHASES         = 3;
endpackage

// ===== src/supply_undervoltage_gate_lockout.sv
// Undervoltage lockout sequencer for a three-phase gate driver
`timescale 1ns/10ps
`default_nettype none
module supply_undervoltage_gate_lockout #(
  parameter int unsigned FILTER_CYC = uvlo_pkg::UV_FILTER_CYC,
  parameter int unsigned FAULT_CYC  = uvlo_pkg::FAULT_MIN_CYC
) (
  input  wire logic       i_sys_clk,        // 40 MHz clock
  input  wire logic       i_srst,           // Synchronous reset, high
  input  wire logic       i_lowside_ok,     // Low-side supply above level
  input  wire logic [2:0] i_highside_ok,    // Boot supplies above level
  input  wire logic [2:0] i_hi_in,          // High-side control inputs
  input  wire logic [2:0] i_lo_in,          // Low-side control inputs
  output var  logic [2:0] o_hi_gate,        // High-side gate drives
  output var  logic [2:0] o_lo_gate,        // Low-side gate drives
  output var  logic       o_fault_out       // Fault, high active
);

  // Timing in brief: every control input passes two flops, then an edge detector
  // compares the synced level with its copy one cycle older. A comparator
  // must read low for FILTER_CYC synced cycles before a trip is taken; a
  // shorter dip clears the counter and the gates keep following inputs.
  // A gate blocked by a trip or by reset comes back only on a fresh
  // low-to-high of its own input, so a level held high across recovery
  // cannot switch a phase on by surprise.
  // Whole state in one register
  typedef struct packed {
    logic [1:0]  lok_s;    // Low ok synchroniser
    logic [5:0]  hok_s;    // High ok synchronisers
    logic [5:0]  hin_s;    // High input synchronisers
    logic [5:0]  lin_s;    // Low input synchronisers
    logic [2:0]  hin_d;    // Delayed high inputs
    logic [2:0]  lin_d;    // Delayed low inputs
    logic [15:0] lcnt;     // Low filter counter
    logic [47:0] hcnt;     // High filter counters
    logic        luv;      // Low side tripped
    logic [2:0]  huv;      // High side tripped
    logic [2:0]  hblk;     // High phase waits for edge
    logic [2:0]  lblk;     // Low phase waits for edge
    logic [15:0] fcnt;     // Fault minimum width
    logic [2:0]  hg;
    logic [2:0]  lg;
    logic        flt;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic       lok;
  logic [2:0] hok;
  logic [2:0] hin;
  logic [2:0] lin;

  // Synchronised views, second stage only
  always_comb begin
    lok = st_reg.lok_s[1];
    for (int i = 0; i < 3; i++) begin
      hok[i] = st_reg.hok_s[2*i+1];
      hin[i] = st_reg.hin_s[2*i+1];
      lin[i] = st_reg.lin_s[2*i+1];
    end
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.lok_s = {st_reg.lok_s[0], i_lowside_ok};
    for (int i = 0; i < 3; i++) begin
      st_next.hok_s[2*i+1] = st_reg.hok_s[2*i];
      st_next.hok_s[2*i]   = i_highside_ok[i];
      st_next.hin_s[2*i+1] = st_reg.hin_s[2*i];
      st_next.hin_s[2*i]   = i_hi_in[i];
      st_next.lin_s[2*i+1] = st_reg.lin_s[2*i];
      st_next.lin_s[2*i]   = i_lo_in[i];
    end
    st_next.hin_d = hin;
    st_next.lin_d = lin;
    // Minimum-width counter; a fresh trip below reloads it
    if (st_reg.fcnt != 16'h0000)
      st_next.fcnt = st_reg.fcnt - 16'h0001;
    // Low-side filter and trip
    if (lok) begin
      st_next.lcnt = 16'h0000;
      st_next.luv  = 1'b0;
    end else if (!st_reg.luv) begin
      if (st_reg.lcnt >= 16'(FILTER_CYC - 1)) begin
        st_next.luv = 1'b1;
        st_next.lblk = 3'h7;
        st_next.fcnt = 16'(FAULT_CYC);
      end else begin
        st_next.lcnt = st_reg.lcnt + 16'h0001;
      end
    end
    // Per-phase high-side filter and edge re-arm
    for (int i = 0; i < 3; i++) begin
      if (hok[i]) begin
        st_next.hcnt[16*i +: 16] = 16'h0000;
        st_next.huv[i] = 1'b0;
      end else if (!st_reg.huv[i]) begin
        if (st_reg.hcnt[16*i +: 16] >= 16'(FILTER_CYC - 1)) begin
          st_next.huv[i]  = 1'b1;
          st_next.hblk[i] = 1'b1;
        end else begin
          st_next.hcnt[16*i +: 16] = st_reg.hcnt[16*i +: 16] + 16'h0001;
        end
      end
      // Fresh rising edge clears the wait once recovered
      if (!st_reg.huv[i] && hin[i] && !st_reg.hin_d[i] && !st_next.huv[i])
        st_next.hblk[i] = 1'b0;
      if (!st_reg.luv && lin[i] && !st_reg.lin_d[i] && !st_next.luv)
        st_next.lblk[i] = 1'b0;
    end
    // Gates pass inputs until trip, blocked while tripped or waiting
    st_next.hg = hin & ~st_next.huv & ~st_next.hblk & ~(st_next.huv);
    st_next.lg = lin & ~{3{st_next.luv}} & ~st_next.lblk;
    // Fault only from the low side, stretched
    st_next.flt = st_next.luv || (st_next.fcnt != 16'h0000);
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_reg <= '0;
      st_reg.hblk <= 3'h7;
      st_reg.lblk <= 3'h7;
      // Inputs read as high so a level held high gives no false edge
      st_reg.hin_s <= 6'h3F;
      st_reg.lin_s <= 6'h3F;
      st_reg.hin_d <= 3'h7;
      st_reg.lin_d <= 3'h7;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    o_hi_gate   = st_reg.hg;
    o_lo_gate   = st_reg.lg;
    o_fault_out = st_reg.flt;
  end

  // Assertions
  AST_LOW_TRIP_GATES: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st_reg.luv |-> o_lo_gate == 3'h0) else $error("low gates on during low trip");
  AST_FAULT_DURING_UV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st_reg.luv |-> o_fault_out) else $error("fault low during low trip");
  AST_FAULT_MIN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(st_reg.luv) |-> o_fault_out [*8]) else $error("fault pulse too short");
  AST_HIGH_NO_FAULT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (!st_reg.luv && st_reg.fcnt == 16'h0000) |-> !o_fault_out) else $error("fault without low trip");
  AST_HIGH_PHASE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_reg.huv & o_hi_gate) == 3'h0) else $error("high gate on while tripped");
  AST_FILTER: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(st_reg.luv) |-> $past(st_reg.lcnt) == 16'(FILTER_CYC - 1)) else $error("early trip");
  AST_REARM_LOW: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $fell(st_reg.lblk[0]) |-> $past(lin[0]) && !$past(st_reg.lin_d[0])) else $error("rearm w/o edge");
  AST_REARM_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $fell(st_reg.hblk[0]) |-> $past(hin[0]) && !$past(st_reg.hin_d[0])) else $error("rearm w/o edge");
  AST_PASS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (!st_reg.luv && st_reg.lblk == 3'h0 && !$past(st_reg.luv) && !st_next.luv)
      |=> o_lo_gate == $past(lin)) else $error("input not passed");

  // Reset leaves every drive off
  AST_RESET_OUT: assert property (@(posedge i_sys_clk)
    $past(i_srst) |-> (o_hi_gate == 3'h0 && o_lo_gate == 3'h0 && !o_fault_out))
    else $error("output on after reset");
  // Fault and width counter on a low trip
  AST_LOW_TRIP_FAULT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(st_reg.luv) |-> o_fault_out)
    else $error("no fault on low trip");
  AST_FAULT_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(st_reg.luv) |-> st_reg.fcnt == 16'(FAULT_CYC))
    else $error("fault width not loaded");
  AST_FAULT_STRETCH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_reg.fcnt != 16'h0000) |-> o_fault_out)
    else $error("fault ended before minimum width");
  AST_LOW_TRIP_ALL: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(st_reg.luv) |-> st_reg.lblk == 3'h7)
    else $error("low phase not blocked on trip");
  AST_LOW_RECOVER_WAIT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $fell(st_reg.luv) |-> st_reg.lblk == 3'h7)
    else $error("low phase armed at recovery");
  AST_OK_CLEARS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    lok |=> st_reg.lcnt == 16'h0000)
    else $error("filter not cleared by good supply");

  // Per-phase checks
  for (genvar p = 0; p < 3; p++) begin : g_phase_chk
    AST_HIGH_FILTER: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      $rose(st_reg.huv[p]) |-> $past(st_reg.hcnt[16*p +: 16]) == 16'(FILTER_CYC - 1))
      else $error("early high trip");
    AST_HIGH_PASS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (!st_reg.huv[p] && !st_reg.hblk[p] && !st_next.huv[p]) |=> o_hi_gate[p] == $past(hin[p]))
      else $error("high input not passed");
    AST_HIGH_RECOVER_WAIT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      $fell(st_reg.huv[p]) |-> st_reg.hblk[p])
      else $error("high phase armed at recovery");
    AST_HIGH_WAIT_OFF: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      st_reg.hblk[p] |-> !o_hi_gate[p])
      else $error("high gate on while waiting");
    AST_LOW_WAIT_OFF: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      st_reg.lblk[p] |-> !o_lo_gate[p])
      else $error("low gate on while waiting");
    AST_HIGH_NO_FAULT_PH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      ($rose(st_reg.huv[p]) && !st_reg.luv && st_reg.fcnt == 16'h0000) |-> !o_fault_out)
      else $error("fault on high trip");
    AST_LOW_REARM_PH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
      $fell(st_reg.lblk[p]) |-> $past(lin[p]) && !$past(st_reg.lin_d[p]))
      else $error("low rearm without edge");
  end

  COV_LOW_TRIP: cover property (@(posedge i_sys_clk) disable iff (i_srst) $rose(st_reg.luv));
  COV_HIGH_TRIP: cover property (@(posedge i_sys_clk) disable iff (i_srst) $rose(st_reg.huv[1]));
  COV_LOW_REARM: cover property (@(posedge i_sys_clk) disable iff (i_srst) $fell(st_reg.lblk[2]));
  COV_FAULT_END: cover property (@(posedge i_sys_clk) disable iff (i_srst) $fell(o_fault_out));
  COV_HIGH_REARM: cover property (@(posedge i_sys_clk) disable iff (i_srst) $fell(st_reg.hblk[0]));

endmodule
`default_nettype wire

// ===== verif/motor_ctrl_model.sv
// Motor controller model that drives the gate control inputs
`timescale 1ns/10ps
`default_nettype none
module motor_ctrl_model (
  input  wire logic       i_sys_clk, // Clock
  input  wire logic       i_stop,    // Stop command
  input  wire logic [2:0] i_hi_req,  // Wanted high gates
  input  wire logic [2:0] i_lo_req,  // Wanted low gates
  output var  logic [2:0] o_hi_in,   // High control inputs
  output var  logic [2:0] o_lo_in    // Low control inputs
);
  // Follows requests set at the falling edge; stop forces all off
  always_comb begin
    o_hi_in = i_stop ? 3'h0 : i_hi_req;
    o_lo_in = i_stop ? 3'h0 : i_lo_req;
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the undervoltage lockout sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int FC = 20;
  logic       clk = 1'b0, srst = 1'b1, lo_ok = 1'b1, stop = 1'b0, chk = 1'b0, fault;
  logic [2:0] hi_ok = 3'h7, hi_req = 3'h7, lo_req = 3'h7, hi_in, lo_in, hi_g, lo_g, m;
  logic [6:0] exp_q[$];
  logic [5:0] r;
  int         n_errors = 0, compares = 0;
  // Clock at 40 MHz
  initial forever #12.5 clk = ~clk;
  motor_ctrl_model i_motor_ctrl_model (.i_sys_clk(clk), .i_stop(stop), .i_hi_req(hi_req),
    .i_lo_req(lo_req), .o_hi_in(hi_in), .o_lo_in(lo_in));
  supply_undervoltage_gate_lockout #(.FILTER_CYC(FC), .FAULT_CYC(10))
    i_supply_undervoltage_gate_lockout (.i_sys_clk(clk), .i_srst(srst), .i_lowside_ok(lo_ok),
    .i_highside_ok(hi_ok), .i_hi_in(hi_in), .i_lo_in(lo_in), .o_hi_gate(hi_g),
    .o_lo_gate(lo_g), .o_fault_out(fault));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic expect_out(input logic [2:0] h, input logic [2:0] l, input logic f);
    exp_q.push_back({h, l, f});
    chk = 1'b1;
    cyc(1);
    chk = 1'b0;
  endtask
  task automatic wait_fault(input logic v);
    int i;
    for (i = 0; i < 40 && fault !== v; i++) cyc(1);
    if (fault !== v) begin
      n_errors++;
      $display("[FAIL] %0t fault wait timed out", $time);
      wrap_up();
    end
  endtask
  task automatic rearm_lo;
    lo_req = 3'h0;
    cyc(3);
    lo_req = 3'h7;
    cyc(6);
  endtask
  // Monitor compares settled outputs with the oldest note
  always @(posedge clk) if (chk) begin
    #1 compares++;
    if (exp_q.size() == 0 || {hi_g, lo_g, fault} !== exp_q[0]) begin
      n_errors++;
      $display("[FAIL] %0t outputs %h %h %b differ", $time, hi_g, lo_g, fault);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  // Main sequence
  initial begin
    void'($urandom(32'h140A));
    cyc(2);
    srst = 1'b0;
    cyc(8);
    expect_out(3'h0, 3'h0, 1'b0);
    stop = 1'b1;
    cyc(3);
    stop = 1'b0;
    cyc(6);
    expect_out(3'h7, 3'h7, 1'b0);
    lo_ok = 1'b0;
    cyc(FC - 8);
    lo_ok = 1'b1;
    cyc(FC);
    expect_out(3'h7, 3'h7, 1'b0);
    lo_ok = 1'b0;
    cyc(FC - 2);
    expect_out(3'h7, 3'h7, 1'b0);
    wait_fault(1'b1);
    cyc(1);
    expect_out(3'h7, 3'h0, 1'b1);
    cyc(30);
    expect_out(3'h7, 3'h0, 1'b1);
    lo_ok = 1'b1;
    wait_fault(1'b0);
    expect_out(3'h7, 3'h0, 1'b0);
    rearm_lo();
    expect_out(3'h7, 3'h7, 1'b0);
    lo_ok = 1'b0;
    wait_fault(1'b1);
    lo_ok = 1'b1;
    cyc(6);
    expect_out(3'h7, 3'h0, 1'b1);
    wait_fault(1'b0);
    rearm_lo();
    repeat (3) begin
      m = 3'h1 << ($urandom % 3);
      hi_ok = ~m;
      cyc(FC + 6);
      expect_out(~m, 3'h7, 1'b0);
      hi_ok = 3'h7;
      cyc(6);
      expect_out(~m, 3'h7, 1'b0);
      hi_req = ~m;
      cyc(3);
      hi_req = 3'h7;
      cyc(6);
      expect_out(3'h7, 3'h7, 1'b0);
    end
    repeat (4) begin
      r = 6'($urandom);
      hi_req = r[5:3];
      lo_req = r[2:0];
      cyc(6);
      expect_out(r[5:3], r[2:0], 1'b0);
    end
    cyc(3);
    wrap_up();
  end
endmodule
`default_nettype wire
